// *** hdl/motion_io_pkg.sv ***
// constants, types and helpers shared by the motion i/o selection logic
`default_nettype none
package motion_io_pkg;

    // ----------------------------------------
    // widths and counts
    // ----------------------------------------
    localparam int NUM_CH = 8;
    localparam int OP_W = 8;
    localparam int POS_W = 32;
    localparam int SEL_W = 5;
    localparam int CH_W = 3;
    localparam int WIN_W = 34;

    // ----------------------------------------
    // setting selectors on the parameter write port
    // ----------------------------------------
    localparam logic [SEL_W-1:0] SEL_MULTI_AREA_OUT = 5'h00;
    localparam logic [SEL_W-1:0] SEL_DSEL0 = 5'h01;
    localparam logic [SEL_W-1:0] SEL_DEND0 = 5'h09;
    localparam logic [SEL_W-1:0] SEL_ZONE_POS = 5'h11;
    localparam logic [SEL_W-1:0] SEL_ZONE_NEG = 5'h12;
    localparam logic [SEL_W-1:0] SEL_ZONE_MODE = 5'h13;
    localparam logic [SEL_W-1:0] SEL_ZONE_BASIS = 5'h14;

    // ----------------------------------------
    // field layouts and reset values
    // ----------------------------------------
    localparam int MULTI_AREA_OUT_SRC_BIT = 0;
    localparam int MULTI_AREA_OUT_OFF_BIT = 1;
    localparam logic [1:0] MULTI_AREA_OUT_RESET = 2'h0;
    localparam logic [POS_W-1:0] ZONE_SET_RESET = 32'h0;
    localparam logic ZONE_MODE_ABS = 1'b0;
    localparam logic ZONE_MODE_REL = 1'b1;
    localparam logic BASIS_FEEDBACK = 1'b0;
    localparam logic BASIS_COMMAND = 1'b1;

    typedef enum logic [1:0] {OP_IDLE, OP_RUN, OP_DONE} op_state_t;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic signed [WIN_W-1:0] ext(input logic [POS_W-1:0] v);
        return signed'({{(WIN_W-POS_W){v[POS_W-1]}}, v});
    endfunction

    // window test with bounds taken in either order
    function automatic logic in_window(input logic signed [WIN_W-1:0] pos,
                                       input logic signed [WIN_W-1:0] a,
                                       input logic signed [WIN_W-1:0] b);
        logic signed [WIN_W-1:0] lo;
        logic signed [WIN_W-1:0] hi;
        lo = (a < b) ? a : b;
        hi = (a < b) ? b : a;
        return (pos >= lo) && (pos <= hi);
    endfunction

endpackage
`default_nettype wire

// *** hdl/zone_cfg_if.sv ***
// positions and zone settings passed from the selector to the zone comparator
`timescale 1ns/1ps
`default_nettype none
interface zone_cfg_if;
    logic [31:0] feedback_pos;
    logic [31:0] command_pos;
    logic [31:0] target_pos;
    logic [31:0] pos_set;
    logic [31:0] neg_set;
    logic range_mode;
    logic basis;

    modport src (output feedback_pos, command_pos, target_pos, pos_set, neg_set,
                 range_mode, basis);
    modport dst (input feedback_pos, command_pos, target_pos, pos_set, neg_set,
                 range_mode, basis);
endinterface
`default_nettype wire

// *** hdl/zone_window.sv ***
// zone comparator for the first zone output
`timescale 1ns/1ps
`default_nettype none
module zone_window
    import motion_io_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    zone_cfg_if.dst cfg,
    output logic zone_out
);

    // ----------------------------------------
    // window bounds
    // ----------------------------------------
    wire logic signed [WIN_W-1:0] pos_sel;
    wire logic signed [WIN_W-1:0] center;
    wire logic signed [WIN_W-1:0] bound_a;
    wire logic signed [WIN_W-1:0] bound_b;
    wire logic hit;

    assign pos_sel = (cfg.basis == BASIS_COMMAND) ? ext(cfg.command_pos)
                                                  : ext(cfg.feedback_pos);
    // relative mode: offset from target, then width either side
    assign center = WIN_W'(ext(cfg.target_pos) + ext(cfg.pos_set));
    assign bound_a = (cfg.range_mode == ZONE_MODE_REL) ? WIN_W'(center - ext(cfg.neg_set))
                                                       : ext(cfg.pos_set);
    assign bound_b = (cfg.range_mode == ZONE_MODE_REL) ? WIN_W'(center + ext(cfg.neg_set))
                                                       : ext(cfg.neg_set);
    assign hit = in_window(pos_sel, bound_a, bound_b);

    always_ff @(posedge clock) begin
        if (rst) begin
            zone_out <= 1'b0;
        end else begin
            zone_out <= hit;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    zone_abs_a: assert property (@(posedge clock) disable iff (rst)
        (cfg.range_mode == ZONE_MODE_ABS && cfg.basis == BASIS_FEEDBACK
         && signed'(cfg.feedback_pos) <= signed'(cfg.pos_set)
         && signed'(cfg.feedback_pos) >= signed'(cfg.neg_set)) |=> zone_out)
        else $error("zone off inside absolute window");

    zone_rel_a: assert property (@(posedge clock) disable iff (rst)
        (cfg.range_mode == ZONE_MODE_REL && cfg.basis == BASIS_COMMAND
         && cfg.command_pos == cfg.target_pos && cfg.pos_set == 32'h0
         && cfg.neg_set == 32'h0) |=> zone_out)
        else $error("zone off at relative window centre");

    zone_outside_a: assert property (@(posedge clock) disable iff (rst)
        (cfg.range_mode == ZONE_MODE_ABS && cfg.basis == BASIS_COMMAND
         && cfg.pos_set == 32'h0 && cfg.neg_set == 32'h0
         && cfg.command_pos != 32'h0) |=> !zone_out)
        else $error("zone on outside window");

endmodule // zone_window
`default_nettype wire

// *** hdl/motion_io_select.sv ***
// motion i/o selection: area output, direct-select starts, completion outputs, zone 0
`timescale 1ns/1ps
`default_nettype none
module motion_io_select
    import motion_io_pkg::*;
#(
    parameter int CHANNELS = NUM_CH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic param_wr,
    input wire logic [SEL_W-1:0] param_sel,
    input wire logic [POS_W-1:0] param_data,
    output logic param_err,
    output logic [1:0] multi_area_out_source,
    input wire logic [CHANNELS-1:0] direct_select_in,
    output logic start_req,
    output logic [OP_W-1:0] start_op,
    input wire logic op_complete,
    input wire logic [OP_W-1:0] op_complete_num,
    input wire logic [POS_W-1:0] feedback_pos,
    input wire logic [POS_W-1:0] command_pos,
    input wire logic [POS_W-1:0] target_pos,
    input wire logic [POS_W-1:0] multi_area_out_low,
    input wire logic [POS_W-1:0] multi_area_out_high,
    output logic multi_area_out,
    output logic [CHANNELS-1:0] op_done_out,
    output logic zone_out0
);

    // ----------------------------------------
    // setting storage
    // ----------------------------------------
    logic [1:0] multi_area_out_src;
    logic [OP_W-1:0] dsel_op [CHANNELS];
    logic [OP_W-1:0] dend_op [CHANNELS];
    logic [POS_W-1:0] zone_pos;
    logic [POS_W-1:0] zone_neg;
    logic zone_mode;
    logic zone_basis;
    logic [CHANNELS-1:0] dsel_prev;
    logic [CH_W-1:0] first_ch;
    op_state_t op_state;
    op_state_t next_op_state;

    function automatic logic hit_ch(input logic [SEL_W-1:0] sel,
                                    input logic [SEL_W-1:0] base, input int n);
        return sel == SEL_W'(int'(base) + n);
    endfunction

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    wire logic byte_ok;
    wire logic mode2_ok;
    wire logic bit_ok;
    wire logic wr_multi_area_out;
    wire logic wr_zone_pos;
    wire logic wr_zone_neg;
    wire logic wr_zone_mode;
    wire logic wr_zone_basis;
    wire logic [CHANNELS-1:0] wr_dsel;
    wire logic [CHANNELS-1:0] wr_dend;
    wire logic bad_write;

    assign byte_ok = (param_data[POS_W-1:OP_W] == '0);
    assign mode2_ok = (param_data[POS_W-1:2] == '0);
    assign bit_ok = (param_data[POS_W-1:1] == '0);
    assign wr_multi_area_out = param_wr && param_sel == SEL_MULTI_AREA_OUT && mode2_ok;
    assign wr_zone_pos = param_wr && param_sel == SEL_ZONE_POS;
    assign wr_zone_neg = param_wr && param_sel == SEL_ZONE_NEG;
    assign wr_zone_mode = param_wr && param_sel == SEL_ZONE_MODE && bit_ok;
    assign wr_zone_basis = param_wr && param_sel == SEL_ZONE_BASIS && bit_ok;

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_wr
            assign wr_dsel[g] = param_wr && hit_ch(param_sel, SEL_DSEL0, g) && byte_ok;
            assign wr_dend[g] = param_wr && hit_ch(param_sel, SEL_DEND0, g) && byte_ok;
        end
    endgenerate

    // refused values and unknown selectors leave every setting unchanged
    assign bad_write = param_wr && !(wr_multi_area_out || wr_zone_pos || wr_zone_neg
                                     || wr_zone_mode || wr_zone_basis
                                     || (|wr_dsel) || (|wr_dend));

    always_ff @(posedge clock) begin
        if (rst) begin
            multi_area_out_src <= MULTI_AREA_OUT_RESET;
            zone_pos <= ZONE_SET_RESET;
            zone_neg <= ZONE_SET_RESET;
            zone_mode <= ZONE_MODE_ABS;
            zone_basis <= BASIS_FEEDBACK;
            param_err <= 1'b0;
        end else begin
            if (wr_multi_area_out) multi_area_out_src <= param_data[1:0];
            if (wr_zone_pos) zone_pos <= param_data;
            if (wr_zone_neg) zone_neg <= param_data;
            if (wr_zone_mode) zone_mode <= param_data[0];
            if (wr_zone_basis) zone_basis <= param_data[0];
            param_err <= bad_write;
        end
    end

    generate
        for (g = 0; g < CHANNELS; g++) begin : g_map
            always_ff @(posedge clock) begin
                if (rst) begin
                    dsel_op[g] <= OP_W'(g);
                    dend_op[g] <= OP_W'(g);
                end else begin
                    if (wr_dsel[g]) dsel_op[g] <= param_data[OP_W-1:0];
                    if (wr_dend[g]) dend_op[g] <= param_data[OP_W-1:0];
                end
            end
        end
    endgenerate

    assign multi_area_out_source = multi_area_out_src;

    // ----------------------------------------
    // direct-select starts
    // ----------------------------------------
    wire logic [CHANNELS-1:0] dsel_rise;
    assign dsel_rise = direct_select_in & ~dsel_prev;

    // lowest input wins when several rise together
    always_comb begin
        first_ch = '0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (dsel_rise[i]) first_ch = CH_W'(i);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            dsel_prev <= '0;
            start_req <= 1'b0;
            start_op <= '0;
        end else begin
            dsel_prev <= direct_select_in;
            start_req <= |dsel_rise;
            if (|dsel_rise) start_op <= dsel_op[first_ch];
        end
    end

    // ----------------------------------------
    // operation progress
    // ----------------------------------------
    always_comb begin
        case (op_state)
            OP_IDLE: next_op_state = start_req ? OP_RUN : OP_IDLE;
            OP_RUN: next_op_state = op_complete ? OP_DONE : OP_RUN;
            OP_DONE: next_op_state = start_req ? OP_RUN : OP_DONE;
            default: next_op_state = OP_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            op_state <= OP_IDLE;
        end else begin
            op_state <= next_op_state;
        end
    end

    // ----------------------------------------
    // completion outputs
    // ----------------------------------------
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_done
            wire logic done_set;
            assign done_set = op_complete && op_complete_num == dend_op[g];
            // a completion in the start cycle is kept
            always_ff @(posedge clock) begin
                if (rst) begin
                    op_done_out[g] <= 1'b0;
                end else begin
                    op_done_out[g] <= done_set || (op_done_out[g] && !start_req);
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // multi-area output
    // ----------------------------------------
    wire logic signed [WIN_W-1:0] multi_area_out_pos;
    wire logic multi_area_out_hit;
    wire logic multi_area_out_blocked;

    assign multi_area_out_pos = multi_area_out_src[MULTI_AREA_OUT_SRC_BIT] ? ext(command_pos) : ext(feedback_pos);
    assign multi_area_out_hit = in_window(multi_area_out_pos, ext(multi_area_out_low), ext(multi_area_out_high));
    assign multi_area_out_blocked = multi_area_out_src[MULTI_AREA_OUT_OFF_BIT] && op_state == OP_DONE;

    always_ff @(posedge clock) begin
        if (rst) begin
            multi_area_out <= 1'b0;
        end else begin
            multi_area_out <= multi_area_out_hit && !multi_area_out_blocked;
        end
    end

    // ----------------------------------------
    // zone 0
    // ----------------------------------------
    zone_cfg_if zone_cfg ();

    assign zone_cfg.feedback_pos = feedback_pos;
    assign zone_cfg.command_pos = command_pos;
    assign zone_cfg.target_pos = target_pos;
    assign zone_cfg.pos_set = zone_pos;
    assign zone_cfg.neg_set = zone_neg;
    assign zone_cfg.range_mode = zone_mode;
    assign zone_cfg.basis = zone_basis;

    zone_window u_zone (
        .clock(clock),
        .rst(rst),
        .cfg(zone_cfg.dst),
        .zone_out(zone_out0)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence finish_s;
        op_complete && op_state == OP_RUN && multi_area_out_src[MULTI_AREA_OUT_OFF_BIT];
    endsequence

    sequence hold_off_s;
        (!start_req && multi_area_out_src[MULTI_AREA_OUT_OFF_BIT])[*2];
    endsequence

    multi_area_out_off_a: assert property (@(posedge clock) disable iff (rst)
        finish_s ##1 hold_off_s |-> !multi_area_out)
        else $error("area output on after completion");

    multi_area_out_cmd_a: assert property (@(posedge clock) disable iff (rst)
        (multi_area_out_src == 2'h1 && in_window(ext(command_pos), ext(multi_area_out_low), ext(multi_area_out_high)))
        |=> multi_area_out)
        else $error("area output ignores command position");

    reset_defaults_a: assert property (@(posedge clock)
        rst |=> (multi_area_out_source == 2'h0 && zone_pos == 32'h0 && zone_neg == 32'h0
                 && dsel_op[CHANNELS-1] == OP_W'(CHANNELS - 1)
                 && dend_op[CHANNELS-1] == OP_W'(CHANNELS - 1)))
        else $error("settings not at reset values");

    dsel_start_a: assert property (@(posedge clock) disable iff (rst)
        (dsel_rise == 8'h80 && CHANNELS == NUM_CH)
        |=> start_req && start_op == $past(dsel_op[CHANNELS-1]))
        else $error("direct select started wrong operation");

    range_refuse_a: assert property (@(posedge clock) disable iff (rst)
        (param_wr && param_sel == SEL_DSEL0 && param_data[POS_W-1:OP_W] != '0)
        |=> param_err && $stable(dsel_op[0]))
        else $error("out of range number accepted");

    done_set_a: assert property (@(posedge clock) disable iff (rst)
        (op_complete && op_complete_num == dend_op[0]) |=> op_done_out[0])
        else $error("completion output missed its operation");

    done_clear_a: assert property (@(posedge clock) disable iff (rst)
        (start_req && !op_complete) |=> op_done_out == '0)
        else $error("completion output kept over a new start");

endmodule // motion_io_select
`default_nettype wire

// *** verif/motion_core_model.sv ***
// motion core stand-in: answers a start with a completion after a set delay unless lat is zero
`timescale 1ns/1ps
`default_nettype none
module motion_core_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic start_req,
    input wire logic [7:0] start_op,
    input wire logic [7:0] lat,
    output logic op_complete,
    output logic [7:0] op_complete_num
);
    logic [7:0] cnt;
    logic [7:0] num;

    // ----------------------------------------
    // completion timing
    // ----------------------------------------
    // lat of zero stalls forever; number shows junk outside the pulse
    always_ff @(posedge clock) begin
        op_complete <= 1'b0;
        op_complete_num <= ~op_complete_num;
        if (rst) begin
            cnt <= 8'h00;
            num <= 8'h00;
            op_complete_num <= 8'h5a;
        end else if (start_req) begin
            cnt <= lat;
            num <= start_op;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
            if (cnt == 8'h01) begin
                op_complete <= 1'b1;
                op_complete_num <= num;
            end
        end
    end
endmodule // motion_core_model
`default_nettype wire

// *** verif/tb_motion_io_select.sv ***
// self-checking bench for the motion i/o selection block
`timescale 1ns/1ps
`default_nettype none
module tb_motion_io_select;
    import motion_io_pkg::*;

    logic clock = 1'b0;
    logic rst = 1'b1;
    logic param_wr = 1'b0;
    logic [4:0] param_sel = 5'h00;
    logic [31:0] param_data = 32'h0;
    logic [7:0] dsi = 8'h00;
    logic [31:0] fb = 32'h0;
    logic [31:0] cmd = 32'h0;
    logic [31:0] tgt = 32'h0;
    logic [31:0] alo = 32'hfffffff6;
    logic [31:0] ahi = 32'h0000000a;
    logic [7:0] lat = 8'h02;
    logic param_err, start_req, op_complete, multi_area_out, zone_out0;
    logic [1:0] multi_area_out_source;
    logic [7:0] start_op, op_complete_num, op_done_out;
    int n_errors = 0;
    int num_checks = 0;

    initial forever #4 clock = ~clock;

    motion_io_select i_dut (.clock(clock), .rst(rst), .param_wr(param_wr),
        .param_sel(param_sel), .param_data(param_data), .param_err(param_err),
        .multi_area_out_source(multi_area_out_source), .direct_select_in(dsi), .start_req(start_req),
        .start_op(start_op), .op_complete(op_complete), .op_complete_num(op_complete_num),
        .feedback_pos(fb), .command_pos(cmd), .target_pos(tgt), .multi_area_out_low(alo),
        .multi_area_out_high(ahi), .multi_area_out(multi_area_out), .op_done_out(op_done_out),
        .zone_out0(zone_out0));

    motion_core_model i_core (.clock(clock), .rst(rst), .start_req(start_req),
        .start_op(start_op), .lat(lat), .op_complete(op_complete),
        .op_complete_num(op_complete_num));

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [4:0] sel, input logic [31:0] d, input logic err);
        @(posedge clock);
        param_wr <= 1'b1;
        param_sel <= sel;
        param_data <= d;
        @(posedge clock);
        param_wr <= 1'b0;
        #1 check(param_err, err);
    endtask

    task automatic pulse(input int n, input logic [7:0] op);
        @(posedge clock);
        dsi <= 8'h01 << n;
        @(posedge clock);
        #1 check(start_req, 1'b1);
        check(start_op, op);
        @(posedge clock);
        dsi <= 8'h00;
        #1 check(start_req, 1'b0);
    endtask

    task automatic wait_cmp();
        int k;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (op_complete !== 1'b1 && k < 40);
        check(op_complete, 1'b1);
        #1;
    endtask

    task automatic area_run(input logic [1:0] src, input logic er, input logic ea);
        wr(SEL_MULTI_AREA_OUT, {30'h0, src}, 1'b0);
        check(multi_area_out_source, src);
        lat <= 8'h14;
        pulse(0, 8'h00);
        @(posedge clock);
        #1 check(multi_area_out, er);
        wait_cmp();
        repeat (2) @(posedge clock);
        #1 check(multi_area_out, ea);
    endtask

    task automatic zchk(input logic [31:0] f, input logic [31:0] c, input logic e);
        @(posedge clock);
        fb <= f;
        cmd <= c;
        @(posedge clock);
        @(posedge clock);
        #1 check(zone_out0, e);
    endtask

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        #1 check(multi_area_out_source, 2'h0);
        check(op_done_out, 8'h00);
        zchk(32'h0, 32'h0, 1'b1);
        zchk(32'h1, 32'h0, 1'b0);
        for (int n = 0; n < 8; n++) begin
            pulse(n, 8'(n));
            wait_cmp();
            check(op_done_out, 8'h01 << n);
        end
        wr(SEL_DSEL0 + 5'h03, 32'h000000ff, 1'b0);
        wr(SEL_DEND0 + 5'h05, 32'h000000ff, 1'b0);
        wr(SEL_DSEL0 + 5'h03, 32'h00000100, 1'b1);
        wr(SEL_DSEL0, 32'h00000100, 1'b1);
        wr(5'h1f, 32'h0, 1'b1);
        pulse(3, 8'hff);
        wait_cmp();
        check(op_done_out, 8'h20);
        wr(SEL_MULTI_AREA_OUT, 32'h4, 1'b1);
        cmd <= 32'h00000064;
        for (int s = 0; s < 4; s++) begin
            area_run(2'(s), !s[0], !s[0] && !s[1]);
        end
        cmd <= 32'h00000005;
        area_run(2'h3, 1'b1, 1'b0);
        area_run(2'h1, 1'b1, 1'b1);
        wr(SEL_ZONE_POS, 32'h00000064, 1'b0);
        wr(SEL_ZONE_NEG, 32'hffffff9c, 1'b0);
        zchk(32'h00000032, 32'h0, 1'b1);
        zchk(32'h00000065, 32'h0, 1'b0);
        zchk(32'hffffff9c, 32'h0, 1'b1);
        wr(SEL_ZONE_BASIS, 32'h1, 1'b0);
        wr(SEL_ZONE_BASIS, 32'h2, 1'b1);
        zchk(32'h0, 32'h000000c8, 1'b0);
        zchk(32'h000000c8, 32'hffffffce, 1'b1);
        wr(SEL_ZONE_BASIS, 32'h0, 1'b0);
        wr(SEL_ZONE_MODE, 32'h2, 1'b1);
        wr(SEL_ZONE_MODE, 32'h1, 1'b0);
        tgt <= 32'h000003e8;
        wr(SEL_ZONE_POS, 32'h0000000a, 1'b0);
        wr(SEL_ZONE_NEG, 32'h00000005, 1'b0);
        zchk(32'h000003f7, 32'h0, 1'b1);
        zchk(32'h000003f8, 32'h0, 1'b0);
        zchk(32'h000003ed, 32'h0, 1'b1);
        zchk(32'h000003ec, 32'h0, 1'b0);
        wr(SEL_ZONE_MODE, 32'h0, 1'b0);
        wr(SEL_ZONE_POS, 32'h7fffffff, 1'b0);
        wr(SEL_ZONE_NEG, 32'h80000000, 1'b0);
        zchk(32'h80000000, 32'h0, 1'b1);
        zchk(32'h7fffffff, 32'h0, 1'b1);
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        #1 check(multi_area_out_source, 2'h0);
        pulse(3, 8'h03);
        zchk(32'h00000005, 32'h0, 1'b0);
        wr(SEL_ZONE_BASIS, 32'h1, 1'b0);
        zchk(32'h0, 32'h00000005, 1'b0);
        wr(SEL_ZONE_MODE, 32'h1, 1'b0);
        zchk(32'h0, 32'h000003e8, 1'b1);
        close_out();
    end

    initial begin
        repeat (5000) @(posedge clock);
        n_errors++;
        close_out();
    end
endmodule // tb_motion_io_select
`default_nettype wire
